//--- hw/asrw_pkg.sv
// constants, register map and types of the serial receiver with wake
package asrw_pkg;

	// register indices on the local register port
	localparam logic [2:0] OFS_RX_STATUS  = 3'h0;
	localparam logic [2:0] OFS_TX_STATUS  = 3'h1;
	localparam logic [2:0] OFS_BAUD_CTRL  = 3'h2;
	localparam logic [2:0] OFS_DIV_HIGH   = 3'h3;
	localparam logic [2:0] OFS_DIV_LOW    = 3'h4;
	localparam logic [2:0] OFS_RX_DATA    = 3'h5;
	localparam logic [2:0] OFS_TX_DATA    = 3'h6;
	localparam logic [2:0] OFS_IRQ_CTRL   = 3'h7;

	// receive_status_control fields
	localparam int RS_SERIAL_PORT_EN  = 7;
	localparam int RS_NINTH_EN        = 6;
	localparam int RS_SINGLE_EN       = 5;
	localparam int RS_CONT_EN         = 4;
	localparam int RS_ADDR_DET_EN     = 3;
	localparam int RS_FRAMING_ERR     = 2;
	localparam int RS_OVERRUN_ERR     = 1;
	localparam int RS_NINTH_BIT       = 0;

	// transmit_status_control fields
	localparam int TS_SYNC_MODE       = 4;
	localparam int TS_HIGH_SPEED      = 2;
	localparam int TS_SHIFTER_EMPTY   = 1;
	localparam logic [7:0] TS_WR_MASK = 8'hFD;

	// baud_control fields
	localparam int BC_RX_IDLE         = 6;
	localparam int BC_RX_INVERT       = 5;
	localparam int BC_TX_INVERT       = 4;
	localparam int BC_WIDE_GEN        = 3;
	localparam int BC_WAKE_EN         = 1;
	localparam int BC_AUTO_RATE_EN    = 0;

	// interrupt control fields
	localparam int IC_RX_FLAG         = 0;
	localparam int IC_RX_ENABLE       = 1;

	// reset values
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [7:0] RST_TXSTAT = 8'h02;

	// oversampling and character lengths
	localparam logic [3:0] MID_SAMPLE   = 4'h7;
	localparam logic [1:0] X64_PRESCALE = 2'h3;
	localparam logic [3:0] BITS_8       = 4'h8;
	localparam logic [3:0] BITS_9       = 4'h9;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_DATA  = 2'b11,
		ST_STOP  = 2'b10
	} asrw_state_e;

endpackage

//--- hw/asrw_edge_det.sv
// one-register edge detector on a synchronous line
`timescale 1ns/1ps
module asrw_edge_det (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// line
	input  wire logic line,
	output logic      fall,
	output logic      rise
);
	logic line_q;

	// idle line is high after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= 1'b1;
		end else begin
			line_q <= line;
		end
	end

	assign fall = line_q & ~line;
	assign rise = ~line_q & line;
endmodule // asrw_edge_det

//--- hw/asrw_baud_gen.sv
// divisor and prescaler giving one pulse per sixteenth of a bit
`timescale 1ns/1ps
module asrw_baud_gen (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// configuration
	input  wire logic        run,
	input  wire logic        wide,
	input  wire logic        high_speed,
	input  wire logic [15:0] divisor,
	// output
	output logic             sample_tick
);
	logic [15:0] cnt_q;
	logic [1:0]  pre_q;
	logic        brg_tick;
	logic        x64;

	assign x64      = ~wide & ~high_speed;
	assign brg_tick = run & (cnt_q == 16'h0000);

	// divisor counter, low byte only in 8-bit mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
		end else if (!run || brg_tick) begin
			cnt_q <= wide ? divisor : {8'h00, divisor[7:0]};
		end else begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end

	// extra divide by four in x64 mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 2'h0;
		end else if (!run || !x64) begin
			pre_q <= 2'h0;
		end else if (brg_tick) begin
			pre_q <= pre_q + 2'h1;
		end
	end

	assign sample_tick = brg_tick & (!x64 || pre_q == asrw_pkg::X64_PRESCALE);
endmodule // asrw_baud_gen

//--- hw/asrw_receiver.sv
// asynchronous serial receiver with address detect and wake on break
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module asrw_receiver (
	// clock and reset
	input  wire logic       CLOCK,
	input  wire logic       RST_N,
	// register port
	input  wire logic [2:0] ADDR,
	input  wire logic [7:0] WR_DATA,
	input  wire logic       WR_EN,
	input  wire logic       RD_EN,
	output logic      [7:0] RD_DATA,
	// serial line and power state
	input  wire logic       SERIAL_INPUT_LINE,
	input  wire logic       SLEEP,
	// events
	output logic            RECEIVE_IRQ,
	output logic            WAKE_REQUEST
);
	// control registers
	logic       serial_port_enable_q;
	logic       ninth_bit_receive_enable_q;
	logic       single_receive_enable_q;
	logic       continuous_receive_enable_q;
	logic       address_detect_enable_q;
	logic [7:0] tx_status_q;
	logic       receive_polarity_invert_q;
	logic       transmit_polarity_invert_q;
	logic       wide_rate_generator_select_q;
	logic       wake_on_break_enable_q;
	logic       auto_rate_detect_enable_q;
	logic [7:0] div_high_q;
	logic [7:0] div_low_q;
	logic [7:0] tx_data_q;
	logic       receive_interrupt_enable_q;

	// status and buffer
	logic       buf_full_q;
	logic [7:0] buf_data_q;
	logic       received_ninth_bit_q;
	logic       framing_error_flag_q;
	logic       overrun_error_flag_q;
	logic       wake_flag_q;
	logic       wake_seen_q;

	// frame engine
	asrw_pkg::asrw_state_e state_q;
	asrw_pkg::asrw_state_e state_d;
	logic [3:0] samp_q;
	logic [3:0] bit_cnt_q;
	logic [8:0] shift_q;

	// outputs
	logic [7:0] rd_data_q;
	logic       irq_q;
	logic       wake_req_q;

	// decoded strobes and conditions
	logic       wr_rx_status;
	logic       wr_tx_status;
	logic       wr_baud_ctrl;
	logic       rd_rx_data;
	logic       line;
	logic       line_fall;
	logic       line_rise;
	logic       async_mode;
	logic       rx_run;
	logic       sample_tick;
	logic       mid_sample;
	logic [3:0] char_bits;
	logic       char_done;
	logic [7:0] char_data;
	logic       char_ninth;
	logic       char_pass;
	logic       wake_event;
	logic       wake_clear;
	logic       receive_interrupt_flag;
	logic [7:0] rd_mux;

	assign wr_rx_status = WR_EN && ADDR == asrw_pkg::OFS_RX_STATUS;
	assign wr_tx_status = WR_EN && ADDR == asrw_pkg::OFS_TX_STATUS;
	assign wr_baud_ctrl = WR_EN && ADDR == asrw_pkg::OFS_BAUD_CTRL;
	assign rd_rx_data   = RD_EN && ADDR == asrw_pkg::OFS_RX_DATA;

	assign line       = SERIAL_INPUT_LINE ^ receive_polarity_invert_q;
	assign async_mode = serial_port_enable_q & ~tx_status_q[asrw_pkg::TS_SYNC_MODE];

	// receiver may run only when enabled, awake and not watching for wake
	assign rx_run = async_mode & continuous_receive_enable_q & ~wake_on_break_enable_q
		& ~SLEEP & ~overrun_error_flag_q;

	asrw_edge_det u_edge (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.line  (line),
		.fall  (line_fall),
		.rise  (line_rise)
	);

	asrw_baud_gen u_baud (
		.clk         (CLOCK),
		.rst_n       (RST_N),
		.run         (rx_run),
		.wide        (wide_rate_generator_select_q),
		.high_speed  (tx_status_q[asrw_pkg::TS_HIGH_SPEED]),
		.divisor     ({div_high_q, div_low_q}),
		.sample_tick (sample_tick)
	);

	assign mid_sample = sample_tick && samp_q == asrw_pkg::MID_SAMPLE;
	assign char_bits  = ninth_bit_receive_enable_q ? asrw_pkg::BITS_9 : asrw_pkg::BITS_8;
	assign char_done  = state_q == asrw_pkg::ST_STOP && mid_sample;

	// eight-bit characters sit one place higher in the shifter
	assign char_data  = ninth_bit_receive_enable_q ? shift_q[7:0] : shift_q[8:1];
	assign char_ninth = ninth_bit_receive_enable_q & shift_q[8];

	// address detect drops data characters, ninth bit clear, in nine-bit mode only
	assign char_pass = ~(address_detect_enable_q & ninth_bit_receive_enable_q & ~char_ninth);

	// next state of the frame engine
	always_comb begin
		state_d = state_q;
		case (state_q)
			asrw_pkg::ST_IDLE: begin
				if (line_fall) begin
					state_d = asrw_pkg::ST_START;
				end
			end
			asrw_pkg::ST_START: begin
				if (mid_sample) begin
					state_d = line ? asrw_pkg::ST_IDLE : asrw_pkg::ST_DATA;
				end
			end
			asrw_pkg::ST_DATA: begin
				if (mid_sample && bit_cnt_q == char_bits - 4'h1) begin
					state_d = asrw_pkg::ST_STOP;
				end
			end
			asrw_pkg::ST_STOP: begin
				if (mid_sample) begin
					state_d = asrw_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = asrw_pkg::ST_IDLE;
			end
		endcase
	end

	// frame engine state, held idle while not running
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= asrw_pkg::ST_IDLE;
		end else if (!rx_run) begin
			state_q <= asrw_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// sample counter within a bit
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			samp_q <= 4'h0;
		end else if (state_q == asrw_pkg::ST_IDLE) begin
			samp_q <= 4'h0;
		end else if (sample_tick) begin
			samp_q <= samp_q + 4'h1;
		end
	end

	// data bit counter and shifter, lsb first
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			bit_cnt_q <= 4'h0;
			shift_q   <= 9'h000;
		end else if (state_q != asrw_pkg::ST_DATA) begin
			bit_cnt_q <= 4'h0;
		end else if (mid_sample) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			shift_q   <= {line, shift_q[8:1]};
		end
	end

	// receive buffer with its ninth bit and framing error
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			buf_full_q           <= 1'b0;
			buf_data_q           <= asrw_pkg::RST_BYTE;
			received_ninth_bit_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
		end else if (char_done && char_pass && (!buf_full_q || rd_rx_data)) begin
			// a read in the same cycle frees the buffer, new character wins
			buf_full_q           <= 1'b1;
			buf_data_q           <= char_data;
			received_ninth_bit_q <= char_ninth;
			framing_error_flag_q <= ~line;
		end else if (rd_rx_data) begin
			buf_full_q <= 1'b0;
		end
	end

	// overrun latches until continuous enable is cleared
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			overrun_error_flag_q <= 1'b0;
		end else if (char_done && char_pass && buf_full_q && !rd_rx_data) begin
			overrun_error_flag_q <= 1'b1;
		end else if (!continuous_receive_enable_q) begin
			overrun_error_flag_q <= 1'b0;
		end
	end

	// wake watching runs on the system clock, sampler not needed
	assign wake_event = wake_on_break_enable_q & async_mode & ~wake_seen_q & line_fall;
	assign wake_clear = wake_on_break_enable_q & wake_seen_q & line_rise;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			wake_seen_q <= 1'b0;
		end else if (wake_event) begin
			wake_seen_q <= 1'b1;
		end else if (wake_clear || !wake_on_break_enable_q) begin
			wake_seen_q <= 1'b0;
		end
	end

	// wake flag; a new event beats a data read
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			wake_flag_q <= 1'b0;
		end else if (wake_event) begin
			wake_flag_q <= 1'b1;
		end else if (rd_rx_data) begin
			wake_flag_q <= 1'b0;
		end
	end

	assign receive_interrupt_flag = buf_full_q | wake_flag_q;

	// receive status control
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			serial_port_enable_q        <= 1'b0;
			ninth_bit_receive_enable_q  <= 1'b0;
			single_receive_enable_q     <= 1'b0;
			continuous_receive_enable_q <= 1'b0;
			address_detect_enable_q     <= 1'b0;
		end else if (wr_rx_status) begin
			serial_port_enable_q        <= WR_DATA[asrw_pkg::RS_SERIAL_PORT_EN];
			ninth_bit_receive_enable_q  <= WR_DATA[asrw_pkg::RS_NINTH_EN];
			single_receive_enable_q     <= WR_DATA[asrw_pkg::RS_SINGLE_EN];
			continuous_receive_enable_q <= WR_DATA[asrw_pkg::RS_CONT_EN];
			address_detect_enable_q     <= WR_DATA[asrw_pkg::RS_ADDR_DET_EN];
		end
	end

	// transmit status control, only mode bits matter here
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			tx_status_q <= asrw_pkg::RST_TXSTAT;
		end else if (wr_tx_status) begin
			tx_status_q <= (WR_DATA & asrw_pkg::TS_WR_MASK) | asrw_pkg::RST_TXSTAT;
		end
	end

	// baud control; software write beats the hardware clear of wake enable
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			receive_polarity_invert_q    <= 1'b0;
			transmit_polarity_invert_q   <= 1'b0;
			wide_rate_generator_select_q <= 1'b0;
			wake_on_break_enable_q       <= 1'b0;
			auto_rate_detect_enable_q    <= 1'b0;
		end else if (wr_baud_ctrl) begin
			receive_polarity_invert_q    <= WR_DATA[asrw_pkg::BC_RX_INVERT];
			transmit_polarity_invert_q   <= WR_DATA[asrw_pkg::BC_TX_INVERT];
			wide_rate_generator_select_q <= WR_DATA[asrw_pkg::BC_WIDE_GEN];
			wake_on_break_enable_q       <= WR_DATA[asrw_pkg::BC_WAKE_EN];
			auto_rate_detect_enable_q    <= WR_DATA[asrw_pkg::BC_AUTO_RATE_EN];
		end else if (wake_clear) begin
			wake_on_break_enable_q <= 1'b0;
		end
	end

	// divisor, transmit data and interrupt enable
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			div_high_q                 <= asrw_pkg::RST_BYTE;
			div_low_q                  <= asrw_pkg::RST_BYTE;
			tx_data_q                  <= asrw_pkg::RST_BYTE;
			receive_interrupt_enable_q <= 1'b0;
		end else if (WR_EN) begin
			case (ADDR)
				asrw_pkg::OFS_DIV_HIGH: div_high_q <= WR_DATA;
				asrw_pkg::OFS_DIV_LOW:  div_low_q  <= WR_DATA;
				asrw_pkg::OFS_TX_DATA:  tx_data_q  <= WR_DATA;
				asrw_pkg::OFS_IRQ_CTRL: begin
					receive_interrupt_enable_q <= WR_DATA[asrw_pkg::IC_RX_ENABLE];
				end
				default: begin
				end
			endcase
		end
	end

	// read mux, unimplemented bits zero
	always_comb begin
		rd_mux = 8'h00;
		case (ADDR)
			asrw_pkg::OFS_RX_STATUS: begin
				rd_mux[asrw_pkg::RS_SERIAL_PORT_EN] = serial_port_enable_q;
				rd_mux[asrw_pkg::RS_NINTH_EN]       = ninth_bit_receive_enable_q;
				rd_mux[asrw_pkg::RS_SINGLE_EN]      = single_receive_enable_q;
				rd_mux[asrw_pkg::RS_CONT_EN]        = continuous_receive_enable_q;
				rd_mux[asrw_pkg::RS_ADDR_DET_EN]    = address_detect_enable_q;
				rd_mux[asrw_pkg::RS_FRAMING_ERR]    = framing_error_flag_q;
				rd_mux[asrw_pkg::RS_OVERRUN_ERR]    = overrun_error_flag_q;
				rd_mux[asrw_pkg::RS_NINTH_BIT]      = received_ninth_bit_q;
			end
			asrw_pkg::OFS_TX_STATUS: rd_mux = tx_status_q;
			asrw_pkg::OFS_BAUD_CTRL: begin
				rd_mux[asrw_pkg::BC_RX_IDLE]      = state_q == asrw_pkg::ST_IDLE;
				rd_mux[asrw_pkg::BC_RX_INVERT]    = receive_polarity_invert_q;
				rd_mux[asrw_pkg::BC_TX_INVERT]    = transmit_polarity_invert_q;
				rd_mux[asrw_pkg::BC_WIDE_GEN]     = wide_rate_generator_select_q;
				rd_mux[asrw_pkg::BC_WAKE_EN]      = wake_on_break_enable_q;
				rd_mux[asrw_pkg::BC_AUTO_RATE_EN] = auto_rate_detect_enable_q;
			end
			asrw_pkg::OFS_DIV_HIGH: rd_mux = div_high_q;
			asrw_pkg::OFS_DIV_LOW:  rd_mux = div_low_q;
			asrw_pkg::OFS_RX_DATA:  rd_mux = buf_data_q;
			asrw_pkg::OFS_TX_DATA:  rd_mux = tx_data_q;
			asrw_pkg::OFS_IRQ_CTRL: begin
				rd_mux[asrw_pkg::IC_RX_FLAG]   = receive_interrupt_flag;
				rd_mux[asrw_pkg::IC_RX_ENABLE] = receive_interrupt_enable_q;
			end
			default: rd_mux = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rd_data_q <= 8'h00;
		end else if (RD_EN) begin
			rd_data_q <= rd_mux;
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	// interrupt request and wake request
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			irq_q      <= 1'b0;
			wake_req_q <= 1'b0;
		end else begin
			irq_q      <= receive_interrupt_flag & receive_interrupt_enable_q;
			wake_req_q <= wake_flag_q;
		end
	end

	assign RD_DATA      = rd_data_q;
	assign RECEIVE_IRQ  = irq_q;
	assign WAKE_REQUEST = wake_req_q;
endmodule // asrw_receiver

//--- bench/asrw_receiver_chk.sv
// port assertions for the serial receiver with wake
`timescale 1ns/1ps
module asrw_receiver_chk (
	// clock and reset
	input wire logic       CLOCK,
	input wire logic       RST_N,
	// register port
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic       WR_EN,
	input wire logic       RD_EN,
	input wire logic [7:0] RD_DATA,
	// line and events
	input wire logic       SERIAL_INPUT_LINE,
	input wire logic       SLEEP,
	input wire logic       RECEIVE_IRQ,
	input wire logic       WAKE_REQUEST
);
	logic       ie_q;
	logic [5:0] line_h_q;

	// shadow of the interrupt enable bit
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			ie_q <= 1'b0;
		else if (WR_EN && ADDR == asrw_pkg::OFS_IRQ_CTRL)
			ie_q <= WR_DATA[asrw_pkg::IC_RX_ENABLE];
	end

	// recent history of the line
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			line_h_q <= 6'h3F;
		else
			line_h_q <= {line_h_q[4:0], SERIAL_INPUT_LINE};
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	a_read_data_idle: assert property (!$past(RD_EN) |-> RD_DATA == 8'h00)
		else $error("read data not zero outside read cycle");
	a_irq_needs_enable: assert property (RECEIVE_IRQ |-> (ie_q || $past(ie_q)))
		else $error("interrupt raised while disabled");
	a_wake_sets_irq: assert property (WAKE_REQUEST && $past(ie_q) |-> RECEIVE_IRQ)
		else $error("wake flag without interrupt");
	a_read_clears_irq: assert property (RD_EN && ADDR == asrw_pkg::OFS_RX_DATA && RECEIVE_IRQ
		|-> ##2 !RECEIVE_IRQ)
		else $error("data read did not clear interrupt");
	a_baud_zero_bits: assert property (RD_EN && ADDR == asrw_pkg::OFS_BAUD_CTRL
		|=> RD_DATA[7] == 1'b0 && RD_DATA[2] == 1'b0)
		else $error("unimplemented baud bits not zero");
	a_irq_reg_zero: assert property (RD_EN && ADDR == asrw_pkg::OFS_IRQ_CTRL |=> RD_DATA[7:2] == 6'h00)
		else $error("unimplemented interrupt bits not zero");
	a_enable_readback: assert property (WR_EN && ADDR == asrw_pkg::OFS_IRQ_CTRL ##1
		RD_EN && ADDR == asrw_pkg::OFS_IRQ_CTRL |=> RD_DATA[1] == $past(WR_DATA[1], 2))
		else $error("interrupt enable read back wrong");
	a_wake_after_edge: assert property ($rose(WAKE_REQUEST) |-> line_h_q != 6'h00 && line_h_q != 6'h3F)
		else $error("wake flag without line transition");
	a_sleep_no_rx: assert property (SLEEP && $past(SLEEP, 2) && $past(ie_q, 2) && $rose(RECEIVE_IRQ)
		|-> WAKE_REQUEST)
		else $error("character received during sleep");

	c_rx_irq: cover property ($rose(RECEIVE_IRQ));
	c_wake_sleep: cover property (WAKE_REQUEST && SLEEP);
	c_data_read: cover property (RD_EN && ADDR == asrw_pkg::OFS_RX_DATA && RECEIVE_IRQ);
endmodule // asrw_receiver_chk

bind asrw_receiver asrw_receiver_chk u_chk (
	.CLOCK             (CLOCK),
	.RST_N             (RST_N),
	.ADDR              (ADDR),
	.WR_DATA           (WR_DATA),
	.WR_EN             (WR_EN),
	.RD_EN             (RD_EN),
	.RD_DATA           (RD_DATA),
	.SERIAL_INPUT_LINE (SERIAL_INPUT_LINE),
	.SLEEP             (SLEEP),
	.RECEIVE_IRQ       (RECEIVE_IRQ),
	.WAKE_REQUEST      (WAKE_REQUEST)
);

//--- bench/asrw_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module asrw_tx_model (
	// clock
	input  wire logic clk,
	// line
	output logic      line
);
	logic lvl = 1'b1;
	logic inv = 1'b0;
	int   bt  = 32;

	assign line = lvl ^ inv;

	// hold a level from the next edge on
	task automatic level(input logic v);
		@(posedge clk);
		lvl <= v;
	endtask

	// start, data lsb first, stop, then back to idle high
	task automatic send(input logic [8:0] d, input int nbits, input logic stop_bit);
		for (int i = 0; i <= nbits + 1; i++) begin
			@(posedge clk);
			lvl <= (i == 0) ? 1'b0 : (i <= nbits) ? d[i-1] : stop_bit;
			repeat (bt - 1) @(posedge clk);
		end
		@(posedge clk);
		lvl <= 1'b1;
	endtask
endmodule // asrw_tx_model

//--- bench/asrw_receiver_test.sv
// register-level testbench of the serial receiver with wake
`timescale 1ns/1ps
module asrw_receiver_test;
	localparam logic [2:0] A_RS = asrw_pkg::OFS_RX_STATUS;
	localparam logic [2:0] A_TS = asrw_pkg::OFS_TX_STATUS;
	localparam logic [2:0] A_BC = asrw_pkg::OFS_BAUD_CTRL;
	localparam logic [2:0] A_RD = asrw_pkg::OFS_RX_DATA;
	localparam logic [2:0] A_IC = asrw_pkg::OFS_IRQ_CTRL;

	logic       CLOCK;
	logic       RST_N;
	logic [2:0] ADDR;
	logic [7:0] WR_DATA;
	logic       WR_EN;
	logic       RD_EN;
	logic [7:0] RD_DATA;
	logic       SLEEP;
	logic       line;
	logic       RECEIVE_IRQ;
	logic       WAKE_REQUEST;
	logic [7:0] rbuf;
	int         fails;
	int         total_checks;

	asrw_receiver DUT (
		.CLOCK             (CLOCK),
		.RST_N             (RST_N),
		.ADDR              (ADDR),
		.WR_DATA           (WR_DATA),
		.WR_EN             (WR_EN),
		.RD_EN             (RD_EN),
		.RD_DATA           (RD_DATA),
		.SERIAL_INPUT_LINE (line),
		.SLEEP             (SLEEP),
		.RECEIVE_IRQ       (RECEIVE_IRQ),
		.WAKE_REQUEST      (WAKE_REQUEST)
	);

	asrw_tx_model u_tx (
		.clk  (CLOCK),
		.line (line)
	);

	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge CLOCK);
		fails++;
		test_done();
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	// outputs are looked at mid-cycle, where they are settled
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
		@(negedge CLOCK);
	endtask

	// every access starts on a rising edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR    <= a;
		WR_DATA <= d;
		WR_EN   <= 1'b1;
		@(posedge CLOCK);
		WR_EN <= 1'b0;
		@(negedge CLOCK);
	endtask

	task automatic rd(input logic [2:0] a);
		@(posedge CLOCK);
		ADDR  <= a;
		RD_EN <= 1'b1;
		@(posedge CLOCK);
		RD_EN <= 1'b0;
		@(negedge CLOCK);
		rbuf = RD_DATA;
	endtask

	// write then read back with no gap between the strobes
	task automatic wrrd(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR    <= a;
		WR_DATA <= d;
		WR_EN   <= 1'b1;
		@(posedge CLOCK);
		WR_EN <= 1'b0;
		RD_EN <= 1'b1;
		@(posedge CLOCK);
		RD_EN <= 1'b0;
		@(negedge CLOCK);
		rbuf = RD_DATA;
	endtask

	task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a);
		chk8(rbuf & m, e);
	endtask

	initial begin
		ADDR    = 3'h0;
		WR_DATA = 8'h00;
		WR_EN   = 1'b0;
		RD_EN   = 1'b0;
		SLEEP   = 1'b0;
		RST_N   = 1'b0;
		fails   = 0;
		total_checks = 0;
		repeat (10) @(posedge CLOCK);
		RST_N <= 1'b1;
		// reset values; idle bit masked
		for (int a = 0; a < 8; a++) begin
			rdc(3'(a), (a == 2) ? 8'hBF : 8'hFF, (a == 1) ? 8'h02 : 8'h00);
		end
		wr(A_BC, 8'hFF);
		rdc(A_BC, 8'hBF, 8'h3B);
		wrrd(A_IC, 8'hFF);
		chk8(rbuf, 8'h02);
		wr(asrw_pkg::OFS_DIV_LOW, 8'h01);
		wr(asrw_pkg::OFS_DIV_HIGH, 8'h00);
		wr(A_BC, 8'h08);
		wr(A_IC, 8'h02);
		wr(A_RS, 8'h90);
		// plain character
		u_tx.send(9'h0C5, 8, 1'b1);
		tick(2);
		chkb(RECEIVE_IRQ, 1'b1);
		rdc(A_RS, 8'hFF, 8'h90);
		rdc(A_RD, 8'hFF, 8'hC5);
		tick(1);
		chkb(RECEIVE_IRQ, 1'b0);
		// flag without interrupt
		wr(A_IC, 8'h00);
		u_tx.send(9'h05E, 8, 1'b1);
		tick(2);
		chkb(RECEIVE_IRQ, 1'b0);
		rdc(A_IC, 8'hFF, 8'h01);
		rdc(A_RD, 8'hFF, 8'h5E);
		wr(A_IC, 8'h02);
		// nine data bits
		wr(A_RS, 8'hD0);
		u_tx.send(9'h13A, 9, 1'b1);
		tick(2);
		rdc(A_RS, 8'hFF, 8'hD1);
		rdc(A_RD, 8'hFF, 8'h3A);
		// address detect: data dropped, address kept, then all kept
		wr(A_RS, 8'hD8);
		u_tx.send(9'h055, 9, 1'b1);
		tick(2);
		chkb(RECEIVE_IRQ, 1'b0);
		u_tx.send(9'h1A7, 9, 1'b1);
		tick(2);
		rdc(A_RS, 8'hFF, 8'hD9);
		rdc(A_RD, 8'hFF, 8'hA7);
		wr(A_RS, 8'hD0);
		u_tx.send(9'h062, 9, 1'b1);
		tick(2);
		rdc(A_RS, 8'hFF, 8'hD0);
		rdc(A_RD, 8'hFF, 8'h62);
		// stop bit low, then overrun
		wr(A_RS, 8'h90);
		u_tx.send(9'h0F0, 8, 1'b0);
		tick(2);
		rdc(A_RS, 8'hFF, 8'h94);
		rdc(A_RD, 8'hFF, 8'hF0);
		u_tx.send(9'h011, 8, 1'b1);
		u_tx.send(9'h022, 8, 1'b1);
		tick(2);
		rdc(A_RS, 8'hFF, 8'h92);
		rdc(A_RD, 8'hFF, 8'h11);
		u_tx.send(9'h033, 8, 1'b1);
		tick(2);
		chkb(RECEIVE_IRQ, 1'b0);
		wr(A_RS, 8'h80);
		rdc(A_RS, 8'hFF, 8'h80);
		u_tx.send(9'h044, 8, 1'b1);
		tick(2);
		chkb(RECEIVE_IRQ, 1'b0);
		// inverted line
		@(posedge CLOCK) u_tx.inv <= 1'b1;
		wr(A_BC, 8'h28);
		wr(A_RS, 8'h90);
		u_tx.send(9'h0C5, 8, 1'b1);
		tick(2);
		rdc(A_RD, 8'hFF, 8'hC5);
		wr(A_RS, 8'h80);
		@(posedge CLOCK) u_tx.inv <= 1'b0;
		wr(A_BC, 8'h00);
		wr(A_RS, 8'h90);
		// x64 sampling
		u_tx.bt = 128;
		u_tx.send(9'h096, 8, 1'b1);
		tick(2);
		rdc(A_RD, 8'hFF, 8'h96);
		u_tx.bt = 32;
		// x16 by high speed select, high divisor byte ignored
		wr(asrw_pkg::OFS_DIV_HIGH, 8'h05);
		wr(A_TS, 8'h04);
		u_tx.send(9'h069, 8, 1'b1);
		tick(2);
		rdc(A_RD, 8'hFF, 8'h69);
		wr(A_TS, 8'h00);
		wr(asrw_pkg::OFS_DIV_HIGH, 8'h00);
		wr(A_BC, 8'h08);
		// sleep blocks reception
		@(posedge CLOCK) SLEEP <= 1'b1;
		u_tx.send(9'h077, 8, 1'b1);
		tick(2);
		chkb(RECEIVE_IRQ, 1'b0);
		@(posedge CLOCK) SLEEP <= 1'b0;
		rdc(A_IC, 8'hFF, 8'h02);
		// wake on break while asleep
		wr(A_BC, 8'h0A);
		@(posedge CLOCK) SLEEP <= 1'b1;
		u_tx.level(1'b0);
		tick(8);
		chkb(WAKE_REQUEST, 1'b1);
		chkb(RECEIVE_IRQ, 1'b1);
		rdc(A_BC, 8'hBF, 8'h0A);
		u_tx.level(1'b1);
		tick(8);
		rdc(A_BC, 8'hBF, 8'h08);
		@(posedge CLOCK) SLEEP <= 1'b0;
		rd(A_RD);
		tick(1);
		chkb(RECEIVE_IRQ, 1'b0);
		chkb(WAKE_REQUEST, 1'b0);
		rdc(A_RS, 8'hFF, 8'h90);
		// no wake in clocked mode
		wr(A_TS, 8'h10);
		wr(A_BC, 8'h0A);
		u_tx.level(1'b0);
		tick(8);
		chkb(WAKE_REQUEST, 1'b0);
		u_tx.level(1'b1);
		wr(A_BC, 8'h08);
		wr(A_TS, 8'h00);
		test_done();
	end
endmodule // asrw_receiver_test
